/* core/osp_map.vh */
`ifndef OSP_MAP_VH
`define OSP_MAP_VH

// ============================================================
// register byte offsets
`define OSP_OFS_GATE 8'h00
`define OSP_OFS_MMODE 8'h04
`define OSP_OFS_SMODE 8'h08
`define OSP_OFS_MRELOAD 8'h0C
`define OSP_OFS_SRELOAD 8'h10
`define OSP_OFS_MCOUNT 8'h14
`define OSP_OFS_SCOUNT 8'h18
`define OSP_OFS_START 8'h1C
`define OSP_OFS_STOP 8'h20
`define OSP_OFS_OUTCTL 8'h24
`define OSP_OFS_PRESCALE 8'h28

// ============================================================
// channel mode register fields
`define OSP_CKS_HI 15
`define OSP_CKS_LO 14
`define OSP_CCS_BIT 12
`define OSP_MASTER_BIT 11
`define OSP_STS_HI 10
`define OSP_STS_LO 8
`define OSP_CIS_HI 7
`define OSP_CIS_LO 6
`define OSP_MD_HI 3
`define OSP_MD_LO 1
`define OSP_MD_TRIG_BIT 0

// ============================================================
// field encodings
`define OSP_MD_ONE_COUNT 3'h4
`define OSP_STS_PIN 3'h1
`define OSP_STS_MASTER 3'h4
`define OSP_CIS_FALL 2'h0
`define OSP_CIS_RISE 2'h1
`define OSP_CIS_BOTH 2'h2
`define OSP_CKS_A 2'h0
`define OSP_CKS_B 2'h2

// ============================================================
// output control bits
`define OSP_OC_ENABLE_BIT 0
`define OSP_OC_POLARITY_BIT 1
`define OSP_OC_MODE_BIT 2
`define OSP_OC_LEVEL_BIT 3

// ============================================================
// prescaler fields
`define OSP_PS_A_HI 3
`define OSP_PS_A_LO 0
`define OSP_PS_B_HI 7
`define OSP_PS_B_LO 4

// ============================================================
// reset values
`define OSP_RST_MODE 16'h0000
`define OSP_RST_RELOAD 16'h0000
`define OSP_RST_OUTCTL 4'h0
`define OSP_RST_PRESCALE 8'h00

`endif

/* core/osp_one_shot_pulse.v */
//Function
//(R1) delay from valid start trigger is master reload plus two count clocks
//(R2) pulse lasts exactly slave reload count clocks
//(R3) master runs one-count mode, loads its reload value on a start trigger
//(R4) master decrements per count clock, at zero pulses completion and halts
//(R5) master completion is the slave start; slave then loads its reload value
//(R6) slave decrements per count clock, at zero pulses completion and waits
//(R7) output active one count clock after master completion, inactive at slave zero
//(R8) writing master start while enabled also launches the delay count
//(R9) software updates reload values only after the matching completion
//(R10) mode field 100B is one-count; with trigger bit zero, retriggers are ignored
//(R11) edge select 00B falling, 01B rising, 10B both, 11B none
//(R12) master trigger source 001B selects the trigger pin edge
//(R13) slave trigger source 100B selects master completion
//(R14) clock select 00B prescaled clock A, 10B clock B, slave matches master
//(R15) polarity bit 0 gives active-high pulse, 1 gives active-low
//(R16) slave output mode bit 1 gives set/reset slave output; master bit stays 0
//(R17) output enable 1 lets counting drive output, 0 lets level bit drive it
//(R18) start bits set both enable status bits; master then awaits a trigger
//(R19) while running only edge select changes; counters always readable; code still accepts prescaler and output enable writes while running
//(R20) stop bits clear enable status, counters and output hold
//(R21) with output enable zero, written level goes straight to the pin
//(R22) gate off blocks writes and initializes all logic, level bit cleared; code clears the trigger synchroniser and bus flops on SYS_RST_IN only
//(R23) counters and reloads are 16 bits; completions are one-cycle pulses
`timescale 1ns/1ps
`include "osp_map.vh"

module osp_one_shot_pulse (
	// clock and reset
	input wire CLK_IN,
	input wire SYS_RST_IN,
	// avalon-mm slave
	input wire [7:0] ADDRESS_IN,
	input wire READ_IN,
	input wire WRITE_IN,
	input wire [31:0] WRITEDATA_IN,
	input wire [3:0] BYTEENABLE_IN,
	output reg [31:0] READDATA_OUT,
	output reg WAITREQUEST_OUT,
	// link pins
	input wire TRIGGER_PIN_IN,
	output reg PULSE_OUT,
	// completion events
	output reg MASTER_DONE_OUT,
	output reg SLAVE_DONE_OUT
);

	// ============================================================
	// states
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_WAIT = 3'b010;
	localparam [2:0] ST_RUN = 3'b100;

	reg gate_q;
	reg [15:0] mmode_q;
	reg [15:0] smode_q;
	reg [15:0] mreload_q;
	reg [15:0] sreload_q;
	reg [15:0] mcnt_q;
	reg [15:0] scnt_q;
	reg [2:0] mst_q;
	reg [2:0] sst_q;
	reg m_en_q;
	reg s_en_q;
	reg [3:0] outctl_q;
	reg [7:0] ps_q;
	reg [15:0] pre_q;
	reg lvl_q;
	reg sync1_q;
	reg sync2_q;
	reg sync3_q;
	reg pin_q;
	reg sw_trig_q;
	reg [31:0] rdata_d;

	wire clr = SYS_RST_IN | ~gate_q; // [R22]
	wire req = (READ_IN | WRITE_IN) & WAITREQUEST_OUT;
	// a write lands only at the edge that sees waitrequest low
	wire wr = WRITE_IN & ~WAITREQUEST_OUT;
	wire wr_ok = wr & gate_q; // [R22]
	wire [15:0] wmask = {{8{BYTEENABLE_IN[1]}}, {8{BYTEENABLE_IN[0]}}};
	wire [15:0] wdata = WRITEDATA_IN[15:0];

	// ============================================================
	// count clock enables
	wire [3:0] exp_a = ps_q[`OSP_PS_A_HI:`OSP_PS_A_LO];
	wire [3:0] exp_b = ps_q[`OSP_PS_B_HI:`OSP_PS_B_LO];
	wire [15:0] mask_a = (16'h0001 << exp_a) - 16'h0001;
	wire [15:0] mask_b = (16'h0001 << exp_b) - 16'h0001;
	wire tick_a = (pre_q & mask_a) == mask_a;
	wire tick_b = (pre_q & mask_b) == mask_b;
	wire [1:0] m_cks = mmode_q[`OSP_CKS_HI:`OSP_CKS_LO];
	wire [1:0] s_cks = smode_q[`OSP_CKS_HI:`OSP_CKS_LO];
	wire m_tick = (m_cks == `OSP_CKS_B) ? tick_b : tick_a; // [R14]
	wire s_tick = (s_cks == `OSP_CKS_B) ? tick_b : tick_a; // [R14]

	always @(posedge CLK_IN) begin
		if (clr) begin
			pre_q <= 16'h0000;
		end else begin
			pre_q <= pre_q + 16'h0001;
		end
	end

	// ============================================================
	// trigger pin synchroniser and edge detect
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			sync1_q <= TRIGGER_PIN_IN;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			if (sync2_q == sync3_q) begin
				pin_q <= sync3_q;
			end
		end
	end

	wire agree = sync2_q == sync3_q;
	wire rise = agree & sync3_q & ~pin_q;
	wire fall = agree & ~sync3_q & pin_q;
	wire [1:0] cis = mmode_q[`OSP_CIS_HI:`OSP_CIS_LO];
	reg pin_edge;
	always @* begin
		case (cis) // [R11]
			`OSP_CIS_FALL: pin_edge = fall;
			`OSP_CIS_RISE: pin_edge = rise;
			`OSP_CIS_BOTH: pin_edge = rise | fall;
			default: pin_edge = 1'b0;
		endcase
	end

	// ============================================================
	// start and stop triggers
	wire start_wr = wr_ok & (ADDRESS_IN == `OSP_OFS_START) & BYTEENABLE_IN[0];
	wire stop_wr = wr_ok & (ADDRESS_IN == `OSP_OFS_STOP) & BYTEENABLE_IN[0];
	wire m_start = start_wr & WRITEDATA_IN[0];
	wire s_start = start_wr & WRITEDATA_IN[1];
	wire m_stop = stop_wr & WRITEDATA_IN[0];
	wire s_stop = stop_wr & WRITEDATA_IN[1];

	wire m_one = mmode_q[`OSP_MD_HI:`OSP_MD_LO] == `OSP_MD_ONE_COUNT; // [R10]
	wire s_one = smode_q[`OSP_MD_HI:`OSP_MD_LO] == `OSP_MD_ONE_COUNT; // [R10]
	wire m_pin_src = mmode_q[`OSP_STS_HI:`OSP_STS_LO] == `OSP_STS_PIN; // [R12]
	wire s_mst_src = smode_q[`OSP_STS_HI:`OSP_STS_LO] == `OSP_STS_MASTER; // [R13]
	wire m_retrig = mmode_q[`OSP_MD_TRIG_BIT];
	wire s_retrig = smode_q[`OSP_MD_TRIG_BIT];

	// software start on an already enabled master acts as a trigger
	wire m_trig_now = (m_pin_src & pin_edge) | (m_start & m_en_q); // [R8]
	wire m_accept = m_one & (mst_q == ST_WAIT | (mst_q == ST_RUN & m_retrig)); // [R10]

	// ============================================================
	// master channel
	wire m_done = m_tick & (mst_q == ST_RUN) & (mcnt_q == 16'h0000) & m_en_q & ~sw_trig_q;
	wire s_load = m_done & s_en_q & s_one & s_mst_src & (sst_q != ST_RUN | s_retrig); // [R5] [R13]

	always @(posedge CLK_IN) begin
		if (clr) begin
			mst_q <= ST_IDLE;
			mcnt_q <= 16'h0000;
			sw_trig_q <= 1'b0;
			MASTER_DONE_OUT <= 1'b0;
		end else begin
			MASTER_DONE_OUT <= m_done; // [R23]
			if (m_stop | ~m_en_q) begin
				sw_trig_q <= 1'b0;
			end else if (m_trig_now & m_accept) begin
				sw_trig_q <= 1'b1;
			end else if (m_tick & sw_trig_q) begin
				sw_trig_q <= 1'b0;
			end
			case (mst_q)
				ST_IDLE: begin
					if (m_start & ~m_en_q) begin
						mst_q <= ST_WAIT; // [R18]
					end
				end
				ST_WAIT: begin
					if (m_stop) begin
						mst_q <= ST_IDLE; // [R20]
					end else if (m_tick & sw_trig_q) begin
						mcnt_q <= mreload_q; // [R3]
						mst_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (m_stop) begin
						mst_q <= ST_IDLE; // [R20]
					end else if (m_tick & sw_trig_q) begin
						mcnt_q <= mreload_q; // [R10]
					end else if (m_done) begin
						mst_q <= ST_WAIT; // [R4]
					end else if (m_tick) begin
						mcnt_q <= mcnt_q - 16'h0001; // [R4] [R1]
					end
				end
				default: mst_q <= ST_IDLE;
			endcase
		end
	end

	// ============================================================
	// slave channel
	wire s_run = (sst_q == ST_RUN) & s_en_q;
	wire s_done = s_tick & s_run & (scnt_q == 16'h0000) & ~s_load;

	always @(posedge CLK_IN) begin
		if (clr) begin
			sst_q <= ST_IDLE;
			scnt_q <= 16'h0000;
			SLAVE_DONE_OUT <= 1'b0;
		end else begin
			SLAVE_DONE_OUT <= s_done; // [R6] [R23]
			case (sst_q)
				ST_IDLE: begin
					if (s_start & ~s_en_q) begin
						sst_q <= ST_WAIT; // [R18]
					end
				end
				ST_WAIT: begin
					if (s_stop) begin
						sst_q <= ST_IDLE; // [R20]
					end else if (s_load) begin
						scnt_q <= sreload_q; // [R5]
						sst_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (s_stop) begin
						sst_q <= ST_IDLE; // [R20]
					end else if (s_load) begin
						scnt_q <= sreload_q;
					end else if (s_done) begin
						sst_q <= ST_WAIT; // [R6]
					end else if (s_tick) begin
						scnt_q <= scnt_q - 16'h0001; // [R2]
					end
				end
				default: sst_q <= ST_IDLE;
			endcase
		end
	end

	// ============================================================
	// enable status
	always @(posedge CLK_IN) begin
		if (clr) begin
			m_en_q <= 1'b0;
			s_en_q <= 1'b0;
		end else begin
			if (m_stop) begin
				m_en_q <= 1'b0; // [R20]
			end else if (m_start) begin
				m_en_q <= 1'b1; // [R18]
			end
			if (s_stop) begin
				s_en_q <= 1'b0; // [R20]
			end else if (s_start) begin
				s_en_q <= 1'b1; // [R18]
			end
		end
	end

	// ============================================================
	// pulse output
	wire oe = outctl_q[`OSP_OC_ENABLE_BIT];
	wire pol = outctl_q[`OSP_OC_POLARITY_BIT];
	wire omode = outctl_q[`OSP_OC_MODE_BIT];
	// active one count clock after load, inactive once the counter sits at zero
	wire go_active = s_tick & s_run & ~s_load & (scnt_q != 16'h0000); // [R7]
	wire go_idle = s_done; // [R7]
	wire lvl_wr = wr_ok & (ADDRESS_IN == `OSP_OFS_OUTCTL) & BYTEENABLE_IN[0];

	// the pin flop mirrors the level flop so the pin adds no extra clock of lag
	always @(posedge CLK_IN) begin
		if (clr) begin
			lvl_q <= 1'b0; // [R22]
			PULSE_OUT <= 1'b0; // [R22]
		end else if (oe & omode) begin
			if (go_idle) begin
				lvl_q <= pol; // [R15] [R16]
				PULSE_OUT <= pol; // [R17]
			end else if (go_active) begin
				lvl_q <= ~pol; // [R15] [R16]
				PULSE_OUT <= ~pol; // [R17]
			end
		end else if (~oe & lvl_wr) begin
			lvl_q <= WRITEDATA_IN[`OSP_OC_LEVEL_BIT]; // [R17] [R21]
			PULSE_OUT <= WRITEDATA_IN[`OSP_OC_LEVEL_BIT]; // [R21]
		end
	end

	// ============================================================
	// register writes
	wire running = m_en_q | s_en_q;
	wire [15:0] cis_mask = 16'h00C0 & wmask;

	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			gate_q <= 1'b0;
		end else if (wr & (ADDRESS_IN == `OSP_OFS_GATE) & BYTEENABLE_IN[0]) begin
			gate_q <= WRITEDATA_IN[0];
		end
	end

	always @(posedge CLK_IN) begin
		if (clr) begin
			mmode_q <= `OSP_RST_MODE;
			smode_q <= `OSP_RST_MODE;
			mreload_q <= `OSP_RST_RELOAD;
			sreload_q <= `OSP_RST_RELOAD;
			outctl_q <= `OSP_RST_OUTCTL;
			ps_q <= `OSP_RST_PRESCALE;
		end else if (wr_ok) begin
			case (ADDRESS_IN)
				`OSP_OFS_MMODE: begin
					if (running) begin
						mmode_q <= (mmode_q & ~cis_mask) | (wdata & cis_mask); // [R19]
					end else begin
						mmode_q <= (mmode_q & ~wmask) | (wdata & wmask);
					end
				end
				`OSP_OFS_SMODE: begin
					if (~running) begin
						smode_q <= (smode_q & ~wmask) | (wdata & wmask); // [R19]
					end
				end
				`OSP_OFS_MRELOAD: mreload_q <= (mreload_q & ~wmask) | (wdata & wmask); // [R9]
				`OSP_OFS_SRELOAD: sreload_q <= (sreload_q & ~wmask) | (wdata & wmask); // [R9]
				`OSP_OFS_OUTCTL: begin
					if (BYTEENABLE_IN[0]) begin
						outctl_q[`OSP_OC_ENABLE_BIT] <= WRITEDATA_IN[`OSP_OC_ENABLE_BIT];
						if (~running) begin
							outctl_q[`OSP_OC_POLARITY_BIT] <= WRITEDATA_IN[`OSP_OC_POLARITY_BIT]; // [R19]
							outctl_q[`OSP_OC_MODE_BIT] <= WRITEDATA_IN[`OSP_OC_MODE_BIT]; // [R19]
						end
					end
				end
				`OSP_OFS_PRESCALE: begin
					if (BYTEENABLE_IN[0]) begin
						ps_q <= WRITEDATA_IN[7:0];
					end
				end
				default: ps_q <= ps_q;
			endcase
		end
	end

	// ============================================================
	// read mux and waitrequest
	always @* begin
		rdata_d = 32'h00000000;
		case (ADDRESS_IN)
			`OSP_OFS_GATE: rdata_d[0] = gate_q;
			`OSP_OFS_MMODE: rdata_d[15:0] = mmode_q;
			`OSP_OFS_SMODE: rdata_d[15:0] = smode_q;
			`OSP_OFS_MRELOAD: rdata_d[15:0] = mreload_q;
			`OSP_OFS_SRELOAD: rdata_d[15:0] = sreload_q;
			`OSP_OFS_MCOUNT: rdata_d[15:0] = mcnt_q; // [R19]
			`OSP_OFS_SCOUNT: rdata_d[15:0] = scnt_q; // [R19]
			`OSP_OFS_START: rdata_d[1:0] = {s_en_q, m_en_q};
			`OSP_OFS_OUTCTL: rdata_d[3:0] = {lvl_q, outctl_q[2:0]};
			`OSP_OFS_PRESCALE: rdata_d[7:0] = ps_q;
			default: rdata_d = 32'h00000000;
		endcase
	end

	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			WAITREQUEST_OUT <= 1'b1;
			READDATA_OUT <= 32'h00000000;
		end else begin
			if (req) begin
				WAITREQUEST_OUT <= 1'b0;
				if (READ_IN) begin
					READDATA_OUT <= rdata_d;
				end
			end else begin
				WAITREQUEST_OUT <= 1'b1;
			end
		end
	end

endmodule

/* tb/osp_one_shot_pulse_chk.sv */
`timescale 1ns/1ps
`include "osp_map.vh"
module osp_chk (
	// clock and reset
	input wire CLK_IN,
	input wire SYS_RST_IN,
	// bus
	input wire [7:0] ADDRESS_IN,
	input wire READ_IN,
	input wire WRITE_IN,
	input wire [31:0] WRITEDATA_IN,
	input wire [3:0] BYTEENABLE_IN,
	input wire [31:0] READDATA_OUT,
	input wire WAITREQUEST_OUT,
	// pins
	input wire TRIGGER_PIN_IN,
	input wire PULSE_OUT,
	input wire MASTER_DONE_OUT,
	input wire SLAVE_DONE_OUT
);
	// ====
	// shadow of the settings that shape the pulse
	reg g_q;
	reg [3:0] oc_q;
	reg [15:0] s_q;
	reg p0_q;
	reg [15:0] n_q;
	wire acc = WRITE_IN && !WAITREQUEST_OUT;
	wire drv = g_q && oc_q[0] && oc_q[2] && p0_q && s_q != 16'h0000;
	wire act = PULSE_OUT != oc_q[1];
	always @(posedge CLK_IN) begin
		n_q <= MASTER_DONE_OUT ? 16'h0000 : n_q + {15'h0000, act};
		if (SYS_RST_IN || (acc && ADDRESS_IN == `OSP_OFS_GATE && !WRITEDATA_IN[0])) begin
			g_q <= 1'h0;
			oc_q <= 4'h0;
			s_q <= 16'h0000;
			p0_q <= 1'h1;
		end else if (acc) begin
			if (ADDRESS_IN == `OSP_OFS_GATE)
				g_q <= 1'h1;
			if (g_q && ADDRESS_IN == `OSP_OFS_OUTCTL)
				oc_q <= WRITEDATA_IN[3:0];
			if (g_q && ADDRESS_IN == `OSP_OFS_SRELOAD)
				s_q <= WRITEDATA_IN[15:0];
			if (g_q && ADDRESS_IN == `OSP_OFS_PRESCALE)
				p0_q <= WRITEDATA_IN[7:0] == 8'h00;
		end
	end
	// ====
	// properties
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	a_bus_wait: assert property ((READ_IN || WRITE_IN) && WAITREQUEST_OUT |=> !WAITREQUEST_OUT)
		else $error("waitrequest did not drop after one cycle");
	a_mdone_one: assert property (MASTER_DONE_OUT |=> !MASTER_DONE_OUT)
		else $error("master done longer than one cycle");
	a_sdone_one: assert property (SLAVE_DONE_OUT |=> !SLAVE_DONE_OUT)
		else $error("slave done longer than one cycle");
	a_pulse_rise: assert property (drv && MASTER_DONE_OUT |=> act)
		else $error("pulse not active one tick after master done");
	a_pulse_fall: assert property (drv && SLAVE_DONE_OUT |-> !act && $past(act))
		else $error("pulse not ended with slave done");
	a_pulse_width: assert property (drv && SLAVE_DONE_OUT |-> n_q == s_q)
		else $error("pulse width differs from slave reload");
	a_stop_hold: assert property (acc && ADDRESS_IN == `OSP_OFS_STOP && WRITEDATA_IN[1:0] == 2'h3 && g_q
		|-> ##3 ($stable(PULSE_OUT) && !MASTER_DONE_OUT) [*5])
		else $error("output moved after stop");
	a_level_pin: assert property (acc && ADDRESS_IN == `OSP_OFS_OUTCTL && g_q && !oc_q[0] && !WRITEDATA_IN[0]
		|=> ##[0:1] PULSE_OUT == oc_q[3])
		else $error("written level not on the pin");
	a_gate_clear: assert property (acc && ADDRESS_IN == `OSP_OFS_GATE && !WRITEDATA_IN[0]
		|-> ##[1:3] !PULSE_OUT)
		else $error("gate off did not clear the pin");
	c_shot: cover property (drv && SLAVE_DONE_OUT);
	c_stop: cover property (acc && ADDRESS_IN == `OSP_OFS_STOP);
	c_pin: cover property ($rose(TRIGGER_PIN_IN));
endmodule

/* tb/osp_pin_model.sv */
`timescale 1ns/1ps
module osp_pin_model (
	// clock
	input wire clk_in,
	// pins
	input wire pulse_in,
	output reg trig_out
);
	reg last_q = 1'h0;
	int rises = 0;
	initial trig_out = 1'h0;
	// the load counts active-high pulses
	always @(posedge clk_in) begin
		last_q <= pulse_in;
		if (pulse_in === 1'h1 && last_q === 1'h0)
			rises <= rises + 1;
	end
	// one high phase on the trigger pin
	task burst(input int hi_cycles);
		@(posedge clk_in);
		trig_out <= 1'h1;
		repeat (hi_cycles) @(posedge clk_in);
		trig_out <= 1'h0;
	endtask
endmodule

/* tb/tb_osp_one_shot_pulse.sv */
`timescale 1ns/1ps
`include "osp_map.vh"
module tb_osp_one_shot_pulse;
	reg CLK_IN = 1'h0;
	reg SYS_RST_IN = 1'h1;
	reg [7:0] ADDRESS_IN = 8'h00;
	reg READ_IN = 1'h0;
	reg WRITE_IN = 1'h0;
	reg [31:0] WRITEDATA_IN = 32'h0;
	wire [31:0] READDATA_OUT;
	wire WAITREQUEST_OUT, TRIGGER_PIN_IN, PULSE_OUT, MASTER_DONE_OUT, SLAVE_DONE_OUT;
	int errors = 0;
	int checks = 0;
	osp_one_shot_pulse DUT (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .ADDRESS_IN(ADDRESS_IN),
		.READ_IN(READ_IN), .WRITE_IN(WRITE_IN), .WRITEDATA_IN(WRITEDATA_IN), .BYTEENABLE_IN(4'hF),
		.READDATA_OUT(READDATA_OUT), .WAITREQUEST_OUT(WAITREQUEST_OUT), .TRIGGER_PIN_IN(TRIGGER_PIN_IN),
		.PULSE_OUT(PULSE_OUT), .MASTER_DONE_OUT(MASTER_DONE_OUT), .SLAVE_DONE_OUT(SLAVE_DONE_OUT));
	osp_pin_model u_pin (.clk_in(CLK_IN), .pulse_in(PULSE_OUT), .trig_out(TRIGGER_PIN_IN));
	initial begin
		forever #12.5 CLK_IN = ~CLK_IN;
	end
	// ====
	// bus and compare
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task bus(input logic rd, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
		@(posedge CLK_IN);
		ADDRESS_IN <= a;
		WRITEDATA_IN <= {16'h0000, d};
		READ_IN <= rd;
		WRITE_IN <= !rd;
		@(posedge CLK_IN);
		while (WAITREQUEST_OUT !== 1'h0) @(posedge CLK_IN);
		q = READDATA_OUT;
		READ_IN <= 1'h0;
		WRITE_IN <= 1'h0;
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'h0, a, d, q);
	endtask
	task setup(input logic [1:0] cks, input logic [1:0] cis, input logic [7:0] ps,
		input logic [15:0] m, input logic [15:0] s, input logic [3:0] oc);
		wr(`OSP_OFS_GATE, 16'h0000);
		wr(`OSP_OFS_GATE, 16'h0001);
		wr(`OSP_OFS_PRESCALE, {8'h00, ps});
		wr(`OSP_OFS_MMODE, {cks, 3'h1, `OSP_STS_PIN, cis, 2'h0, `OSP_MD_ONE_COUNT, 1'h0});
		wr(`OSP_OFS_SMODE, {cks, 3'h0, `OSP_STS_MASTER, 4'h0, `OSP_MD_ONE_COUNT, 1'h0});
		wr(`OSP_OFS_MRELOAD, m);
		wr(`OSP_OFS_SRELOAD, s);
		wr(`OSP_OFS_OUTCTL, {12'h000, oc & 4'hE});
		wr(`OSP_OFS_OUTCTL, {12'h000, oc});
		wr(`OSP_OFS_START, 16'h0003);
	endtask
	// software start, then delay, gap to active and active width in clocks
	task shot(input logic idle, output int d, output int w, output int g);
		int n;
		wr(`OSP_OFS_START, 16'h0001);
		d = 0;
		while (MASTER_DONE_OUT !== 1'h1 && d < 9000) begin
			@(posedge CLK_IN);
			d++;
		end
		w = 0;
		n = 0;
		g = 0;
		while (SLAVE_DONE_OUT !== 1'h1 && n < 9000) begin
			@(posedge CLK_IN);
			n++;
			if (PULSE_OUT !== idle && w++ == 0)
				g = n;
		end
		if (d >= 9000 || n >= 9000)
			errors++;
	endtask
	// ====
	// scenarios
	task t_basic;
		int d1, w1, g1, d2, w2, g2;
		logic [31:0] v;
		setup(`OSP_CKS_A, `OSP_CIS_RISE, 8'h00, 16'h0002, 16'h0003, 4'h5);
		shot(1'h0, d1, w1, g1);
		chk("width", 32'h3, w1);
		chk("gap", 32'h1, g1);
		bus(1'h1, `OSP_OFS_MCOUNT, 16'h0, v);
		chk("mcount", 32'h0, v);
		bus(1'h1, `OSP_OFS_SCOUNT, 16'h0, v);
		chk("scount", 32'h0, v);
		bus(1'h1, `OSP_OFS_START, 16'h0, v);
		chk("enables", 32'h3, v);
		wr(`OSP_OFS_MRELOAD, 16'h0005);
		wr(`OSP_OFS_SRELOAD, 16'h0001);
		shot(1'h0, d2, w2, g2);
		chk("delay step", 32'h3, d2 - d1);
		chk("width", 32'h1, w2);
	endtask
	task t_clock;
		int d, w, g;
		setup(`OSP_CKS_A, `OSP_CIS_RISE, 8'h21, 16'h0002, 16'h0003, 4'h5);
		shot(1'h0, d, w, g);
		chk("width a", 32'h6, w);
		setup(`OSP_CKS_B, `OSP_CIS_RISE, 8'h21, 16'h0002, 16'h0003, 4'h5);
		shot(1'h0, d, w, g);
		chk("width b", 32'hC, w);
		chk("gap b", 32'h4, g);
	endtask
	task t_pol;
		int d, w, g;
		setup(`OSP_CKS_A, `OSP_CIS_RISE, 8'h00, 16'h0002, 16'h0003, 4'hF);
		chk("idle high", 32'h1, PULSE_OUT);
		shot(1'h1, d, w, g);
		chk("low width", 32'h3, w);
		chk("back high", 32'h1, PULSE_OUT);
	endtask
	task t_edges;
		logic [9:0] ex;
		int n0;
		ex = 10'b01_00_10_01_01;
		for (int i = 0; i < 5; i++) begin
			setup(`OSP_CKS_A, (i == 4) ? 2'h2 : i[1:0], 8'h00, (i == 4) ? 16'h003C : 16'h0002, 16'h0002, 4'h5);
			n0 = u_pin.rises;
			u_pin.burst((i == 4) ? 10 : 40);
			repeat (100) @(posedge CLK_IN);
			chk("pin pulses", {30'h0, ex[2*i+:2]}, u_pin.rises - n0);
		end
	endtask
	task t_stop;
		logic [31:0] v1, v2, v3;
		setup(`OSP_CKS_A, `OSP_CIS_RISE, 8'h00, 16'h07D0, 16'h0003, 4'h5);
		wr(`OSP_OFS_START, 16'h0001);
		bus(1'h1, `OSP_OFS_MCOUNT, 16'h0, v1);
		wr(`OSP_OFS_STOP, 16'h0003);
		bus(1'h1, `OSP_OFS_MCOUNT, 16'h0, v2);
		repeat (20) @(posedge CLK_IN);
		bus(1'h1, `OSP_OFS_MCOUNT, 16'h0, v3);
		chk("counting down", 32'h1, v2 < v1 && v2 != 0);
		chk("count held", v2, v3);
		bus(1'h1, `OSP_OFS_START, 16'h0, v1);
		chk("enables off", 32'h0, v1);
		chk("pin held", 32'h0, PULSE_OUT);
	endtask
	task t_level;
		int d, w, g;
		logic [31:0] v;
		setup(`OSP_CKS_A, `OSP_CIS_RISE, 8'h00, 16'h0002, 16'h0003, 4'h4);
		wr(`OSP_OFS_OUTCTL, 16'h000C);
		repeat (2) @(posedge CLK_IN);
		chk("level high", 32'h1, PULSE_OUT);
		shot(1'h1, d, w, g);
		chk("no drive", 32'h0, w);
		wr(`OSP_OFS_OUTCTL, 16'h0004);
		repeat (2) @(posedge CLK_IN);
		chk("level low", 32'h0, PULSE_OUT);
		wr(`OSP_OFS_OUTCTL, 16'h000C);
		wr(`OSP_OFS_GATE, 16'h0000);
		repeat (3) @(posedge CLK_IN);
		chk("gate clear", 32'h0, PULSE_OUT);
		wr(`OSP_OFS_MRELOAD, 16'h1234);
		bus(1'h1, `OSP_OFS_MRELOAD, 16'h0, v);
		chk("write blocked", 32'h0, v);
		bus(1'h1, 8'h3C, 16'h0, v);
		chk("unmapped", 32'h0, v);
	endtask
	task test_done;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge CLK_IN);
		SYS_RST_IN <= 1'h0;
		t_basic;
		t_clock;
		t_pol;
		t_edges;
		t_stop;
		t_level;
		test_done;
	end
	initial begin
		#500000;
		errors++;
		test_done;
	end
endmodule
bind osp_one_shot_pulse osp_chk u_chk (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .ADDRESS_IN(ADDRESS_IN),
	.READ_IN(READ_IN), .WRITE_IN(WRITE_IN), .WRITEDATA_IN(WRITEDATA_IN), .BYTEENABLE_IN(BYTEENABLE_IN),
	.READDATA_OUT(READDATA_OUT), .WAITREQUEST_OUT(WAITREQUEST_OUT), .TRIGGER_PIN_IN(TRIGGER_PIN_IN),
	.PULSE_OUT(PULSE_OUT), .MASTER_DONE_OUT(MASTER_DONE_OUT), .SLAVE_DONE_OUT(SLAVE_DONE_OUT));
